/* shared/rtcd_cfg.svh */
`ifndef RTCD_CFG_SVH
`define RTCD_CFG_SVH

// Bus geometry
`define RTCD_ADDR_W        8
`define RTCD_DATA_W        32

// Register byte offsets
`define RTCD_OFS_CTRL      8'h00
`define RTCD_OFS_FLAGS     8'h04
`define RTCD_OFS_INT_STAT  8'h08
`define RTCD_OFS_INT_MASK  8'h0C
`define RTCD_OFS_AL1_TIME  8'h10
`define RTCD_OFS_AL1_DATE  8'h14
`define RTCD_OFS_AL2_TIME  8'h18
`define RTCD_OFS_AL2_DATE  8'h1C

// Control register bits
`define RTCD_CTRL_A1IRQ    0
`define RTCD_CTRL_A2IRQ    1
`define RTCD_CTRL_BKUP     2
`define RTCD_CTRL_AL2EN    3
`define RTCD_CTRL_ROUTE    4
`define RTCD_CTRL_PTRHOLD  5
`define RTCD_CTRL_W        6
`define RTCD_CTRL_RST      6'h00

// Flags register bits
`define RTCD_FLG_A1        0
`define RTCD_FLG_A2        1
`define RTCD_FLG_INBKUP    4
`define RTCD_FLG_IRQ1      8
`define RTCD_FLG_SECOND_IRQ_OUTPUT      9

// Alarm time word: seconds, minutes, hours (BCD)
`define RTCD_SEC_LSB       0
`define RTCD_MIN_LSB       8
`define RTCD_HOUR_LSB      16
// Alarm date word: date, month, repeat bits
`define RTCD_DATE_LSB      0
`define RTCD_MON_LSB       8
`define RTCD_RPT_LSB       16

`define RTCD_SEC_W         7
`define RTCD_MIN_W         7
`define RTCD_HOUR_W        6
`define RTCD_DATE_W        6
`define RTCD_MON_W         5
`define RTCD_RPT_W         5

// Interrupt status bits
`define RTCD_IRQ_W         2
`define RTCD_IRQ_RST       2'h0

// Bus responses
`define RTCD_RESP_OKAY     2'h0
`define RTCD_RESP_SLVERR   2'h2

`endif

/* shared/rtcd_pkg.sv */
`include "rtcd_cfg.svh"

package rtcd_pkg;

  typedef logic [`RTCD_ADDR_W-1:0] rtcd_addr_t;
  typedef logic [`RTCD_DATA_W-1:0] rtcd_data_t;
  typedef logic [`RTCD_RPT_W-1:0]  rtcd_rpt_t;

  typedef enum logic [2:0] {
    RTCD_EVERY_SEC,
    RTCD_EVERY_MIN,
    RTCD_EVERY_HOUR,
    RTCD_EVERY_DAY,
    RTCD_EVERY_MONTH,
    RTCD_EVERY_YEAR
  } rtcd_mode_t;

  // Field compare enables, bit order: month, date, hour, min, sec
  typedef logic [4:0] rtcd_cmp_t;

  // Unlisted codes fall back to every second so a bad setting shows fast
  function automatic rtcd_mode_t rtcd_decode(input rtcd_rpt_t rpt);
    rtcd_mode_t m;
    m = RTCD_EVERY_SEC;
    case (rpt)
      5'h1F:   m = RTCD_EVERY_SEC;
      5'h1E:   m = RTCD_EVERY_MIN;
      5'h1C:   m = RTCD_EVERY_HOUR;
      5'h18:   m = RTCD_EVERY_DAY;
      5'h10:   m = RTCD_EVERY_MONTH;
      5'h00:   m = RTCD_EVERY_YEAR;
      default: m = RTCD_EVERY_SEC;
    endcase
    return m;
  endfunction

  function automatic rtcd_cmp_t rtcd_fields(input rtcd_mode_t m);
    rtcd_cmp_t c;
    c = 5'h00;
    unique case (m)
      RTCD_EVERY_SEC:   c = 5'h00;
      RTCD_EVERY_MIN:   c = 5'h01;
      RTCD_EVERY_HOUR:  c = 5'h03;
      RTCD_EVERY_DAY:   c = 5'h07;
      RTCD_EVERY_MONTH: c = 5'h0F;
      RTCD_EVERY_YEAR:  c = 5'h1F;
    endcase
    return c;
  endfunction

endpackage

/* hdl/rtcd_alarm_match.sv */
`timescale 1ns/1ps
`include "rtcd_cfg.svh"

module rtcd_alarm_match (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Calendar and tick
  input  wire logic                   tick,
  input  wire logic [`RTCD_SEC_W-1:0]  cal_sec,
  input  wire logic [`RTCD_MIN_W-1:0]  cal_min,
  input  wire logic [`RTCD_HOUR_W-1:0] cal_hour,
  input  wire logic [`RTCD_DATE_W-1:0] cal_date,
  input  wire logic [`RTCD_MON_W-1:0]  cal_mon,
  // Alarm setting
  input  wire logic                   enable,
  input  wire rtcd_pkg::rtcd_data_t   al_time,
  input  wire rtcd_pkg::rtcd_data_t   al_date,
  // Result
  output logic                        match
);
  import rtcd_pkg::*;

  rtcd_cmp_t  use_f;
  logic [4:0] eq;
  logic       match_next;

  always_comb begin
    use_f = rtcd_fields(rtcd_decode(al_date[`RTCD_RPT_LSB +: `RTCD_RPT_W]));
    eq[0] = cal_sec  == al_time[`RTCD_SEC_LSB  +: `RTCD_SEC_W];
    eq[1] = cal_min  == al_time[`RTCD_MIN_LSB  +: `RTCD_MIN_W];
    eq[2] = cal_hour == al_time[`RTCD_HOUR_LSB +: `RTCD_HOUR_W];
    eq[3] = cal_date == al_date[`RTCD_DATE_LSB +: `RTCD_DATE_W];
    eq[4] = cal_mon  == al_date[`RTCD_MON_LSB  +: `RTCD_MON_W];
    match_next = tick && enable && ((eq | ~use_f) == 5'h1F);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      match <= 1'b0;
    end else begin
      match <= match_next;
    end
  end

endmodule // rtcd_alarm_match

/* hdl/rtcd_alarm_unit.sv */
`timescale 1ns/1ps
`include "rtcd_cfg.svh"

// Behaviour
// - Unknown repeat code acts as every second
// - Alarm match under repeat mask sets flag
// - Flag register read clears both alarm flags
// - First alarm flag drives shared interrupt when enabled
// - Second alarm flag drives second interrupt when enabled
// - Pointer on flags register holds off flags
// - Flag register read releases alarm interrupts
// - Shared interrupt in backup needs backup enable
// - Backup interrupt holds until supply, then read
// - Second alarm enable activates second alarm bytes
// - Second alarm enable resets to zero
// - Disabled second alarm bytes are user storage
// - Second interrupt in backup needs both enables
// - Repeat bits decode to six periods
module rtcd_alarm_unit (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // AXI4-Lite write address
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire rtcd_pkg::rtcd_addr_t   s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire rtcd_pkg::rtcd_data_t   s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // AXI4-Lite write response
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire rtcd_pkg::rtcd_addr_t   s_axi_araddr,
  // AXI4-Lite read data
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output rtcd_pkg::rtcd_data_t        s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  // Time base and calendar from the clock counters
  input  wire logic                   tb_clk,
  input  wire logic [`RTCD_SEC_W-1:0]  cal_sec,
  input  wire logic [`RTCD_MIN_W-1:0]  cal_min,
  input  wire logic [`RTCD_HOUR_W-1:0] cal_hour,
  input  wire logic [`RTCD_DATE_W-1:0] cal_date,
  input  wire logic [`RTCD_MON_W-1:0]  cal_mon,
  // Supply state
  input  wire logic                   on_battery,
  // Interrupt pins and summary interrupt
  output logic                        shared_irq_output_n,
  output logic                        second_irq_output_n,
  output logic                        irq
);
  import rtcd_pkg::*;

  localparam int CAL_W = `RTCD_SEC_W + `RTCD_MIN_W + `RTCD_HOUR_W + `RTCD_DATE_W + `RTCD_MON_W;

  function automatic rtcd_data_t merge(input rtcd_data_t old, input rtcd_data_t nw,
                                       input logic [3:0] strb);
    rtcd_data_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input rtcd_addr_t a);
    return a[1:0] == 2'h0 && a <= `RTCD_OFS_AL2_DATE;
  endfunction

  // Pin synchronisers: first stage read only by the second
  logic [2:0]       tb_sync_reg;
  logic [CAL_W-1:0] cal_meta_reg;
  logic [CAL_W-1:0] cal_sync_reg;
  logic [1:0]       bat_sync_reg;
  logic             tick;
  logic             in_bkup;

  // Register state
  logic [`RTCD_CTRL_W-1:0] ctrl_reg,     ctrl_next;
  rtcd_data_t              al1_time_reg, al1_time_next;
  rtcd_data_t              al1_date_reg, al1_date_next;
  rtcd_data_t              al2_time_reg, al2_time_next;
  rtcd_data_t              al2_date_reg, al2_date_next;
  logic                    flag1_reg,    flag1_next;
  logic                    flag2_reg,    flag2_next;
  logic                    pend1_reg,    pend1_next;
  logic                    pend2_reg,    pend2_next;
  logic                    irq1_n_reg,   irq1_n_next;
  logic                    second_irq_output_n_reg,   second_irq_output_n_next;
  logic [`RTCD_IRQ_W-1:0]  stat_reg,     stat_next;
  logic [`RTCD_IRQ_W-1:0]  mask_reg,     mask_next;
  logic                    irq_reg,      irq_next;

  // Bus state
  logic       aw_hold_reg, aw_hold_next;
  logic       w_hold_reg,  w_hold_next;
  rtcd_addr_t waddr_reg,   waddr_next;
  rtcd_data_t wdata_reg,   wdata_next;
  logic [3:0] wstrb_reg,   wstrb_next;
  logic       bvalid_reg,  bvalid_next;
  logic [1:0] bresp_reg,   bresp_next;
  logic       rvalid_reg,  rvalid_next;
  rtcd_data_t rdata_reg,   rdata_next;
  logic [1:0] rresp_reg,   rresp_next;

  logic       m1;
  logic       m2;
  logic       do_wr;
  logic       do_rd;
  logic       flags_rd;
  logic       ptr_hold;
  logic       set1;
  logic       set2;
  logic       bkup_ok;
  rtcd_data_t rd_val;

  assign tick    = tb_sync_reg[1] && !tb_sync_reg[2];
  assign in_bkup = bat_sync_reg[1];

  rtcd_alarm_match u_match1 (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .tick     (tick),
    .cal_sec  (cal_sync_reg[0 +: `RTCD_SEC_W]),
    .cal_min  (cal_sync_reg[7 +: `RTCD_MIN_W]),
    .cal_hour (cal_sync_reg[14 +: `RTCD_HOUR_W]),
    .cal_date (cal_sync_reg[20 +: `RTCD_DATE_W]),
    .cal_mon  (cal_sync_reg[26 +: `RTCD_MON_W]),
    .enable   (1'b1),
    .al_time  (al1_time_reg),
    .al_date  (al1_date_reg),
    .match    (m1)
  );

  rtcd_alarm_match u_match2 (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .tick     (tick),
    .cal_sec  (cal_sync_reg[0 +: `RTCD_SEC_W]),
    .cal_min  (cal_sync_reg[7 +: `RTCD_MIN_W]),
    .cal_hour (cal_sync_reg[14 +: `RTCD_HOUR_W]),
    .cal_date (cal_sync_reg[20 +: `RTCD_DATE_W]),
    .cal_mon  (cal_sync_reg[26 +: `RTCD_MON_W]),
    .enable   (ctrl_reg[`RTCD_CTRL_AL2EN]),
    .al_time  (al2_time_reg),
    .al_date  (al2_date_reg),
    .match    (m2)
  );

  always_comb begin
    rd_val = '0;
    case (s_axi_araddr)
      `RTCD_OFS_CTRL:     rd_val = {26'h0, ctrl_reg};
      `RTCD_OFS_FLAGS: begin
        rd_val[`RTCD_FLG_A1]     = flag1_reg;
        rd_val[`RTCD_FLG_A2]     = flag2_reg;
        rd_val[`RTCD_FLG_INBKUP] = in_bkup;
        rd_val[`RTCD_FLG_IRQ1]   = !irq1_n_reg;
        rd_val[`RTCD_FLG_SECOND_IRQ_OUTPUT]   = !second_irq_output_n_reg;
      end
      `RTCD_OFS_INT_STAT: rd_val = {30'h0, stat_reg};
      `RTCD_OFS_INT_MASK: rd_val = {30'h0, mask_reg};
      `RTCD_OFS_AL1_TIME: rd_val = al1_time_reg;
      `RTCD_OFS_AL1_DATE: rd_val = al1_date_reg;
      `RTCD_OFS_AL2_TIME: rd_val = al2_time_reg;
      `RTCD_OFS_AL2_DATE: rd_val = al2_date_reg;
      default:            rd_val = '0;
    endcase
  end

  always_comb begin
    // Write channels are taken independently, in either order
    aw_hold_next = aw_hold_reg;
    w_hold_next  = w_hold_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && !aw_hold_reg) begin
      aw_hold_next = 1'b1;
      waddr_next   = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_reg) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = mapped(waddr_reg) ? `RTCD_RESP_OKAY : `RTCD_RESP_SLVERR;
    end

    // Read channel
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    do_rd       = s_axi_arvalid && !rvalid_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (do_rd) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_val;
      rresp_next  = mapped(s_axi_araddr) ? `RTCD_RESP_OKAY : `RTCD_RESP_SLVERR;
    end
    flags_rd = do_rd && s_axi_araddr == `RTCD_OFS_FLAGS;

    // Register writes
    ctrl_next     = ctrl_reg;
    al1_time_next = al1_time_reg;
    al1_date_next = al1_date_reg;
    al2_time_next = al2_time_reg;
    al2_date_next = al2_date_reg;
    mask_next     = mask_reg;
    stat_next     = stat_reg;
    if (do_wr) begin
      case (waddr_reg)
        `RTCD_OFS_CTRL: begin
          ctrl_next = wstrb_reg[0] ? wdata_reg[`RTCD_CTRL_W-1:0] : ctrl_reg;
        end
        `RTCD_OFS_INT_STAT: begin
          if (wstrb_reg[0]) begin
            stat_next = stat_reg & ~wdata_reg[`RTCD_IRQ_W-1:0];
          end
        end
        `RTCD_OFS_INT_MASK: begin
          mask_next = wstrb_reg[0] ? wdata_reg[`RTCD_IRQ_W-1:0] : mask_reg;
        end
        `RTCD_OFS_AL1_TIME: al1_time_next = merge(al1_time_reg, wdata_reg, wstrb_reg);
        `RTCD_OFS_AL1_DATE: al1_date_next = merge(al1_date_reg, wdata_reg, wstrb_reg);
        `RTCD_OFS_AL2_TIME: al2_time_next = merge(al2_time_reg, wdata_reg, wstrb_reg);
        `RTCD_OFS_AL2_DATE: al2_date_next = merge(al2_date_reg, wdata_reg, wstrb_reg);
        default: begin
        end
      endcase
    end

    // Matches seen while the pointer rests on flags wait for it to move
    ptr_hold   = ctrl_reg[`RTCD_CTRL_PTRHOLD];
    pend1_next = ptr_hold && (pend1_reg || m1);
    pend2_next = ptr_hold && (pend2_reg || m2);
    set1       = !ptr_hold && (pend1_reg || m1);
    set2       = !ptr_hold && (pend2_reg || m2);

    // Set beats the read-clear in the same cycle
    flag1_next = (flag1_reg && !flags_rd) || set1;
    flag2_next = (flag2_reg && !flags_rd) || set2;
    if (set1) begin
      stat_next[0] = 1'b1;
    end
    if (set2) begin
      stat_next[1] = 1'b1;
    end

    // Pins: active low; in backup only released after supply returns
    bkup_ok     = !in_bkup || ctrl_reg[`RTCD_CTRL_BKUP];
    irq1_n_next = irq1_n_reg;
    second_irq_output_n_next = second_irq_output_n_reg;
    if (flags_rd && !in_bkup) begin
      irq1_n_next = 1'b1;
      second_irq_output_n_next = 1'b1;
    end
    if (set1 && ctrl_reg[`RTCD_CTRL_A1IRQ] && ctrl_reg[`RTCD_CTRL_ROUTE] && bkup_ok) begin
      irq1_n_next = 1'b0;
    end
    if (set2 && ctrl_reg[`RTCD_CTRL_A2IRQ] && ctrl_reg[`RTCD_CTRL_AL2EN] && bkup_ok) begin
      second_irq_output_n_next = 1'b0;
    end

    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tb_sync_reg  <= 3'h0;
      cal_meta_reg <= '0;
      cal_sync_reg <= '0;
      bat_sync_reg <= 2'h0;
      ctrl_reg     <= `RTCD_CTRL_RST;
      al1_time_reg <= '0;
      al1_date_reg <= '0;
      al2_time_reg <= '0;
      al2_date_reg <= '0;
      flag1_reg    <= 1'b0;
      flag2_reg    <= 1'b0;
      pend1_reg    <= 1'b0;
      pend2_reg    <= 1'b0;
      irq1_n_reg   <= 1'b1;
      second_irq_output_n_reg   <= 1'b1;
      stat_reg     <= `RTCD_IRQ_RST;
      mask_reg     <= `RTCD_IRQ_RST;
      irq_reg      <= 1'b0;
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      waddr_reg    <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `RTCD_RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= `RTCD_RESP_OKAY;
    end else begin
      tb_sync_reg  <= {tb_sync_reg[1:0], tb_clk};
      cal_meta_reg <= {cal_mon, cal_date, cal_hour, cal_min, cal_sec};
      cal_sync_reg <= cal_meta_reg;
      bat_sync_reg <= {bat_sync_reg[0], on_battery};
      ctrl_reg     <= ctrl_next;
      al1_time_reg <= al1_time_next;
      al1_date_reg <= al1_date_next;
      al2_time_reg <= al2_time_next;
      al2_date_reg <= al2_date_next;
      flag1_reg    <= flag1_next;
      flag2_reg    <= flag2_next;
      pend1_reg    <= pend1_next;
      pend2_reg    <= pend2_next;
      irq1_n_reg   <= irq1_n_next;
      second_irq_output_n_reg   <= second_irq_output_n_next;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      irq_reg      <= irq_next;
      aw_hold_reg  <= aw_hold_next;
      w_hold_reg   <= w_hold_next;
      waddr_reg    <= waddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
    end
  end

  // Write readies are the inverted hold flops and read ready the inverted rvalid flop, so each comes from a flop
  assign s_axi_awready       = !aw_hold_reg;
  assign s_axi_wready        = !w_hold_reg;
  assign s_axi_arready       = !rvalid_reg;
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign shared_irq_output_n = irq1_n_reg;
  assign second_irq_output_n = second_irq_output_n_reg;
  assign irq                 = irq_reg;

endmodule // rtcd_alarm_unit

/* verif/rtcd_alarm_checker.sv */
`timescale 1ns/1ps
`include "rtcd_cfg.svh"

module rtcd_alarm_checker (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  // Register bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire rtcd_pkg::rtcd_addr_t s_axi_awaddr,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire rtcd_pkg::rtcd_addr_t s_axi_araddr,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire rtcd_pkg::rtcd_data_t s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  // Supply and pins
  input wire logic                 on_battery,
  input wire logic                 shared_irq_output_n,
  input wire logic                 second_irq_output_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  logic aw_bad_reg;

  // Remembers the write in flight so its response can be judged
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      aw_bad_reg <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      aw_bad_reg <= (s_axi_awaddr > `RTCD_OFS_AL2_DATE) || (s_axi_awaddr[1:0] != 2'h0);
  end

  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  write_resp_a: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (aw_bad_reg ? `RTCD_RESP_SLVERR : `RTCD_RESP_OKAY))
    else $error("wrong write response");
  read_refuse_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > `RTCD_OFS_AL2_DATE |=> s_axi_rresp == `RTCD_RESP_SLVERR
    && s_axi_rdata == '0) else $error("unmapped read not refused");
  irq_release_a: assert property (!on_battery [*6] ##0 (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == `RTCD_OFS_FLAGS) |-> ##[1:4] (shared_irq_output_n
    && second_irq_output_n)) else $error("pins kept after flag read");
  backup_hold_a: assert property (on_battery [*6] |=> !$rose(shared_irq_output_n)
    && !$rose(second_irq_output_n)) else $error("pin released on battery");
endmodule // rtcd_alarm_checker

bind rtcd_alarm_unit rtcd_alarm_checker u_rtcd_alarm_checker (
  .clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .on_battery, .shared_irq_output_n, .second_irq_output_n
);

/* verif/rtcd_tbase_model.sv */
`timescale 1ns/1ps

module rtcd_tbase_model (
  // Request
  input  wire logic run,
  // Time base
  output logic      tb_clk
);
  // Gated and off phase: toggles only while ticks are asked for
  initial begin
    tb_clk = 1'b0;
    forever begin
      wait (run === 1'b1);
      #37;
      while (run === 1'b1) begin
        tb_clk = 1'b1;
        #80;
        tb_clk = 1'b0;
        #80;
      end
    end
  end
endmodule // rtcd_tbase_model

/* verif/tb_rtcd_alarm_unit.sv */
`timescale 1ns/1ps
`include "rtcd_cfg.svh"

module tb_rtcd_alarm_unit;
  import rtcd_pkg::*;
  localparam rtcd_addr_t  CTL = `RTCD_OFS_CTRL;
  localparam rtcd_addr_t  FLG = `RTCD_OFS_FLAGS;
  localparam logic [30:0] ALM = {7'h30, 7'h15, 6'h08, 6'h12, 5'h05};
  localparam int          LSB[5] = '{24, 17, 11, 5, 0};
  localparam rtcd_rpt_t   RPT[7] = '{5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10, 5'h00, 5'h0A};
  localparam int          NCMP[7] = '{0, 1, 2, 3, 4, 5, 0};
  logic       clk_sys, rstn, run, tb_clk, on_battery, irq;
  logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic       s_axi_rvalid, s_axi_rready, shared_irq_output_n, second_irq_output_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic [3:0] s_axi_wstrb;
  rtcd_addr_t s_axi_awaddr, s_axi_araddr;
  rtcd_data_t s_axi_wdata, s_axi_rdata, rd_data;
  logic [6:0] cal_sec, cal_min;
  logic [5:0] cal_hour, cal_date;
  logic [4:0] cal_mon;
  int         error_cnt, tests_run;

  rtcd_alarm_unit u_rtcd_alarm_unit (
    .clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .tb_clk, .cal_sec, .cal_min, .cal_hour, .cal_date,
    .cal_mon, .on_battery, .shared_irq_output_n, .second_irq_output_n, .irq
  );
  rtcd_tbase_model u_rtcd_tbase_model (.run, .tb_clk);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input rtcd_data_t got, input rtcd_data_t exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo();
    chk(1'b0, 1'b1);
    summarize();
  endtask

  // Pins settle a few cycles after their cause, so poll under a bound
  task automatic wait_val(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk(s, v);
    if (s !== v) summarize();
  endtask

  task automatic wr(input rtcd_addr_t a, input rtcd_data_t d,
                    input logic [1:0] e = `RTCD_RESP_OKAY);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
    if (n >= 60) tmo();
  endtask

  task automatic rd(input rtcd_addr_t a);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    if (n >= 60) tmo();
  endtask

  task automatic rdc(input rtcd_addr_t a, input rtcd_data_t e);
    rd(a);
    chk(rd_data, e);
    chk(rd_resp, `RTCD_RESP_OKAY);
  endtask

  // Calendar only moves while the time base stands still
  task automatic tick(input logic [30:0] c);
    int n;
    @(posedge clk_sys);
    {cal_sec, cal_min, cal_hour, cal_date, cal_mon} <= c;
    run <= 1'b1;
    n = 0;
    while (tb_clk !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    run <= 1'b0;
    if (n >= 20) tmo();
    repeat (10) @(posedge clk_sys);
  endtask

  // Fields from index n upward are skewed so only the lower ones agree
  function automatic logic [30:0] cal_of(input int n);
    logic [30:0] c;
    c = ALM;
    for (int k = n; k < 5; k++)
      c = c + (31'h1 << LSB[k]);
    return c;
  endfunction

  initial begin
    {rstn, run, on_battery, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {cal_sec, cal_min, cal_hour, cal_date, cal_mon} = '0;
    s_axi_wstrb = 4'hF;
    error_cnt = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_val(shared_irq_output_n, 1'b1);
    rdc(CTL, 32'h0);
    wr(`RTCD_OFS_AL2_DATE, 32'h12345678);
    rdc(`RTCD_OFS_AL2_DATE, 32'h12345678);
    tick(ALM);
    rdc(FLG, 32'h0);
    rd(8'h40);
    chk(rd_data, 32'h0);
    chk(rd_resp, `RTCD_RESP_SLVERR);
    wr(8'h22, 32'h1, `RTCD_RESP_SLVERR);
    $display("test reset_storage done");
    wr(CTL, 32'h11);
    wr(`RTCD_OFS_INT_MASK, 32'h1);
    wr(`RTCD_OFS_AL1_TIME, 32'h00081530);
    for (int i = 0; i < 7; i++) begin
      wr(`RTCD_OFS_AL1_DATE, {11'h0, RPT[i], 16'h0512});
      tick(cal_of(NCMP[i]));
      wait_val(shared_irq_output_n, 1'b0);
      wait_val(irq, 1'b1);
      rdc(FLG, 32'h101);
      wait_val(shared_irq_output_n, 1'b1);
      rdc(FLG, 32'h0);
      wr(`RTCD_OFS_INT_STAT, 32'h1);
      wait_val(irq, 1'b0);
      if (NCMP[i] > 0) begin
        tick(ALM + (31'h1 << LSB[NCMP[i] - 1]));
        rdc(FLG, 32'h0);
      end
    end
    $display("test repeat_modes done");
    wr(`RTCD_OFS_AL1_DATE, 32'h0);
    wr(CTL, 32'h1B);
    wr(`RTCD_OFS_AL2_TIME, 32'h00081530);
    wr(`RTCD_OFS_AL2_DATE, 32'h001E0512);
    tick(cal_of(1));
    wait_val(second_irq_output_n, 1'b0);
    wait_val(irq, 1'b0);
    rdc(FLG, 32'h202);
    wait_val(second_irq_output_n, 1'b1);
    wr(`RTCD_OFS_INT_MASK, 32'h3);
    wait_val(irq, 1'b1);
    wr(`RTCD_OFS_INT_STAT, 32'h3);
    wait_val(irq, 1'b0);
    $display("test second_alarm done");
    wr(CTL, 32'h3B);
    tick(cal_of(1));
    wait_val(second_irq_output_n, 1'b1);
    rdc(FLG, 32'h0);
    wr(CTL, 32'h1B);
    wait_val(second_irq_output_n, 1'b0);
    rdc(FLG, 32'h202);
    $display("test pointer_hold done");
    on_battery <= 1'b1;
    wr(`RTCD_OFS_AL1_DATE, 32'h001E0512);
    tick(cal_of(1));
    wait_val(shared_irq_output_n, 1'b1);
    wait_val(second_irq_output_n, 1'b1);
    rdc(FLG, 32'h13);
    wr(CTL, 32'h1F);
    tick(cal_of(1));
    rdc(FLG, 32'h313);
    wait_val(shared_irq_output_n, 1'b0);
    wait_val(second_irq_output_n, 1'b0);
    on_battery <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rdc(FLG, 32'h300);
    wait_val(shared_irq_output_n, 1'b1);
    wait_val(second_irq_output_n, 1'b1);
    $display("test backup done");
    summarize();
  end
endmodule // tb_rtcd_alarm_unit
